//--- prd_rx_detect.v
`timescale 1ns/100ps

// Notes on behaviour
// - bit 14 accepts mac 01:80:c2:00:00:0e
// - bit 13 accepts mac 01:1b:19:00:00:00
// - bit 12 accepts group 129 addresses
// - bit 11 accepts group 130 addresses
// - bit 10 accepts group 131 addresses
// - bit 9 accepts group 132 addresses
// - bit 8 accepts 224.0.0.107 / ff02::6b
// - bit 7 accepts custom mac, raw ethernet
// - bit 6 accepts custom mac, udp v6
// - bit 5 accepts custom mac, udp v4
// - bit 4 checks ip destination address
// - bit 3 checks mac destination address
// - bit 2 enables raw ethernet timing messages
// - bit 1 enables udp v6 timing messages
// - bit 0 enables udp v4 timing messages
// - config at 158h, bits 31:15 read zero
module prd_rx_detect #(
    parameter CFG_WIDTH = 15
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // wishbone slave
    input  wire         cyc_i,
    input  wire         stb_i,
    input  wire         we_i,
    input  wire [11:0]  adr_i,
    input  wire [3:0]   sel_i,
    input  wire [31:0]  dat_i,
    output reg  [31:0]  dat_o,
    output reg          ack_o,
    // frame header from receive path
    input  wire         hdr_valid_i,
    input  wire [1:0]   hdr_enc_i,
    input  wire [47:0]  hdr_dst_mac_i,
    input  wire [127:0] hdr_dst_ip_i,
    // classification result and timestamping enable
    output reg          res_valid_o,
    output reg          res_timing_o,
    output reg          ts_enable_o
);
`include "prd_defines.vh"

    // ---------------------------------------------------------------
    // register bus decode
    // ---------------------------------------------------------------
    wire                 bus_req;
    wire                 wr_strobe;
    wire                 cfg_we;
    wire                 mac_hi_we;
    wire                 mac_lo_we;
    wire                 ctl_we;
    wire [CFG_WIDTH-1:0] cfg_q;
    wire [47:0]          mac_q;
    wire [CFG_WIDTH-1:0] cfg_wdata;
    reg  [31:0]          rd_next;
    reg                  ts_en_reg;
    reg  [15:0]          seen_count_reg;
    reg  [15:0]          hit_count_reg;

    // one request per ack; the dropped ack gap keeps us from double taking
    assign bus_req   = cyc_i & stb_i & ~ack_o;
    assign wr_strobe = bus_req & we_i;

    // only full low lanes write fields spanning them; others skipped
    assign cfg_we    = wr_strobe & (adr_i == `PRD_OFS_PARSE_CONFIG) & sel_i[0] & sel_i[1];
    assign mac_hi_we = wr_strobe & (adr_i == `PRD_OFS_MAC_HIGH) & sel_i[0] & sel_i[1];
    assign mac_lo_we = wr_strobe & (adr_i == `PRD_OFS_MAC_LOW) & (&sel_i);
    assign ctl_we    = wr_strobe & (adr_i == `PRD_OFS_CONTROL) & sel_i[0];

    // config writes while timestamping runs are dropped, not queued
    assign cfg_wdata = dat_i[CFG_WIDTH-1:0];

    prd_cfg_store #(
        .CFG_WIDTH (CFG_WIDTH)
    ) u_store (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .cfg_we_i       (cfg_we & ~ts_en_reg),
        .cfg_wdata_i    (cfg_wdata),
        .mac_hi_we_i    (mac_hi_we & ~ts_en_reg),
        .mac_hi_wdata_i (dat_i[15:0]),
        .mac_lo_we_i    (mac_lo_we & ~ts_en_reg),
        .mac_lo_wdata_i (dat_i),
        .cfg_o          (cfg_q),
        .mac_o          (mac_q)
    );

    // read mux; reserved bits and unmapped addresses read zero
    always @* begin
        rd_next = 32'h0000_0000;
        case (adr_i)
            `PRD_OFS_PARSE_CONFIG: rd_next = {{(32-CFG_WIDTH){1'b0}}, cfg_q};
            `PRD_OFS_MAC_HIGH:     rd_next = {16'h0000, mac_q[47:32]};
            `PRD_OFS_MAC_LOW:      rd_next = mac_q[31:0];
            `PRD_OFS_CONTROL:      rd_next = {31'h0000_0000, ts_en_reg};
            `PRD_OFS_STATUS:       rd_next = {hit_count_reg, seen_count_reg};
            default:               rd_next = 32'h0000_0000;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h0000_0000;
            ts_en_reg <= 1'b0;
        end else begin
            ack_o <= bus_req;
            if (bus_req & ~we_i) begin
                dat_o <= rd_next;
            end
            if (ctl_we) begin
                ts_en_reg <= dat_i[0];
            end
        end
    end

    // ---------------------------------------------------------------
    // group address matching
    // ---------------------------------------------------------------
    wire [4:0] grp_en;
    wire [4:0] grp_mac_hit;
    wire [4:0] grp_ip_hit;
    wire [15:0] grp_code [0:4];

    assign grp_en = {cfg_q[`PRD_BIT_IP_FIVE], cfg_q[`PRD_BIT_IP_FOUR],
                     cfg_q[`PRD_BIT_IP_THREE], cfg_q[`PRD_BIT_IP_TWO],
                     cfg_q[`PRD_BIT_IP_ONE]};
    assign grp_code[0] = `PRD_GROUP_ONE;
    assign grp_code[1] = `PRD_GROUP_TWO;
    assign grp_code[2] = `PRD_GROUP_THREE;
    assign grp_code[3] = `PRD_GROUP_FOUR;
    assign grp_code[4] = `PRD_GROUP_FIVE;

    // one matcher per group; the fifth is link local only
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_grp
            prd_mac_match u_match (
                .group_i      (grp_code[g]),
                .link_local_i (g == 4),
                .enc_i        (hdr_enc_i),
                .dst_mac_i    (hdr_dst_mac_i),
                .dst_ip_i     (hdr_dst_ip_i),
                .mac_hit_o    (grp_mac_hit[g]),
                .ip_hit_o     (grp_ip_hit[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // classification
    // ---------------------------------------------------------------
    reg  fmt_ok;
    reg  mac_ok;
    reg  ip_ok;
    reg  timing_next;
    wire mac_check;
    wire ip_check;
    wire custom_hit;

    assign mac_check  = cfg_q[`PRD_BIT_MAC_CHECK];
    assign ip_check   = cfg_q[`PRD_BIT_IP_CHECK];
    assign custom_hit = (hdr_dst_mac_i == mac_q);

    // an entry counts only if enabled; with a check off, its address is free
    always @* begin
        fmt_ok = 1'b0;
        mac_ok = 1'b0;
        ip_ok  = 1'b0;
        case (hdr_enc_i)
            `PRD_ENC_RAW: begin
                fmt_ok = cfg_q[`PRD_BIT_RAW_FMT];
                mac_ok = (cfg_q[`PRD_BIT_L2_ONE] &
                          (hdr_dst_mac_i == `PRD_MAC_L2_ONE)) |
                         (cfg_q[`PRD_BIT_L2_TWO] &
                          (hdr_dst_mac_i == `PRD_MAC_L2_TWO)) |
                         (cfg_q[`PRD_BIT_L2_CUSTOM] & custom_hit);
                ip_ok  = 1'b1;
            end
            `PRD_ENC_V4: begin
                fmt_ok = cfg_q[`PRD_BIT_V4_FMT];
                mac_ok = |(grp_en & grp_mac_hit) |
                         (cfg_q[`PRD_BIT_V4_CUSTOM] & custom_hit);
                ip_ok  = |(grp_en & grp_ip_hit);
            end
            `PRD_ENC_V6: begin
                fmt_ok = cfg_q[`PRD_BIT_V6_FMT];
                mac_ok = |(grp_en & grp_mac_hit) |
                         (cfg_q[`PRD_BIT_V6_CUSTOM] & custom_hit);
                ip_ok  = |(grp_en & grp_ip_hit);
            end
            default: begin
                fmt_ok = 1'b0;
            end
        endcase
        // a check that is off lets any address of that kind through
        timing_next = fmt_ok & (mac_ok | ~mac_check) & (ip_ok | ~ip_check);
    end

    // registered result, one cycle after the header strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            res_valid_o    <= 1'b0;
            res_timing_o   <= 1'b0;
            ts_enable_o    <= 1'b0;
            seen_count_reg <= 16'h0000;
            hit_count_reg  <= 16'h0000;
        end else begin
            res_valid_o  <= hdr_valid_i;
            res_timing_o <= hdr_valid_i & timing_next;
            ts_enable_o  <= ts_en_reg;
            // counters wrap; software takes differences
            if (hdr_valid_i) begin
                seen_count_reg <= seen_count_reg + 16'h0001;
            end
            if (hdr_valid_i & timing_next) begin
                hit_count_reg <= hit_count_reg + 16'h0001;
            end
        end
    end
endmodule

//--- prd_defines.vh
`ifndef PRD_DEFINES_VH
`define PRD_DEFINES_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PRD_OFS_PARSE_CONFIG  12'h158
`define PRD_OFS_MAC_HIGH      12'h300
`define PRD_OFS_MAC_LOW       12'h304
`define PRD_OFS_CONTROL       12'h308
`define PRD_OFS_STATUS        12'h30C

// ---------------------------------------------------------------
// parsing configuration fields
// ---------------------------------------------------------------
`define PRD_CFG_WIDTH         15
`define PRD_CFG_RESET         15'h711F
`define PRD_BIT_L2_ONE        14
`define PRD_BIT_L2_TWO        13
`define PRD_BIT_IP_ONE        12
`define PRD_BIT_IP_TWO        11
`define PRD_BIT_IP_THREE      10
`define PRD_BIT_IP_FOUR       9
`define PRD_BIT_IP_FIVE       8
`define PRD_BIT_L2_CUSTOM     7
`define PRD_BIT_V6_CUSTOM     6
`define PRD_BIT_V4_CUSTOM     5
`define PRD_BIT_IP_CHECK      4
`define PRD_BIT_MAC_CHECK     3
`define PRD_BIT_RAW_FMT       2
`define PRD_BIT_V6_FMT        1
`define PRD_BIT_V4_FMT        0

// ---------------------------------------------------------------
// well-known addresses
// ---------------------------------------------------------------
`define PRD_MAC_L2_ONE        48'h0180_C200_000E
`define PRD_MAC_L2_TWO        48'h011B_1900_0000
`define PRD_MAC_V4_PREFIX     40'h0100_5E00_00
`define PRD_MAC_V6_PREFIX     40'h3333_0000_00
`define PRD_IP4_PREFIX        24'hE000_00
`define PRD_IP6_HI_MASK       16'hFFF0
`define PRD_IP6_HI_GLOBAL     16'hFF00
`define PRD_IP6_HI_LINK       16'hFF02
`define PRD_GROUP_ONE         16'h0181
`define PRD_GROUP_TWO         16'h0182
`define PRD_GROUP_THREE       16'h0183
`define PRD_GROUP_FOUR        16'h0184
`define PRD_GROUP_FIVE        16'h006B

// ---------------------------------------------------------------
// frame encapsulation codes
// ---------------------------------------------------------------
`define PRD_ENC_RAW           2'h0
`define PRD_ENC_V4            2'h1
`define PRD_ENC_V6            2'h2
`define PRD_ENC_NONE          2'h3

`endif

//--- prd_mac_match.v
`timescale 1ns/100ps

// matches a destination mac and ip address against one group entry
module prd_mac_match (
    // group entry
    input  wire [15:0] group_i,
    input  wire        link_local_i,
    // frame fields
    input  wire [1:0]  enc_i,
    input  wire [47:0] dst_mac_i,
    input  wire [127:0] dst_ip_i,
    // results
    output wire        mac_hit_o,
    output wire        ip_hit_o
);
`include "prd_defines.vh"

    wire [39:0] v4_mac_prefix;
    wire [39:0] v6_mac_prefix;
    wire [23:0] v4_ip_prefix;

    // the group code fills the two low octets; only the upper octets are fixed
    assign v4_mac_prefix = `PRD_MAC_V4_PREFIX;
    assign v6_mac_prefix = `PRD_MAC_V6_PREFIX;
    assign v4_ip_prefix  = `PRD_IP4_PREFIX;

    // mac follows the group address, prefix chosen by encapsulation
    assign mac_hit_o = (enc_i == `PRD_ENC_V4) ?
                       (dst_mac_i[47:16] == v4_mac_prefix[39:8] &&
                        dst_mac_i[15:0] == group_i) :
                       (dst_mac_i[47:16] == v6_mac_prefix[39:8] &&
                        dst_mac_i[15:0] == group_i);

    // v6 scope nibble is free for routable groups, fixed ff02 for link local
    assign ip_hit_o = (enc_i == `PRD_ENC_V4) ?
                      (dst_ip_i[31:16] == v4_ip_prefix[23:8] &&
                       dst_ip_i[15:0] == group_i) :
                      ((link_local_i ?
                        (dst_ip_i[127:112] == `PRD_IP6_HI_LINK) :
                        ((dst_ip_i[127:112] & `PRD_IP6_HI_MASK) == `PRD_IP6_HI_GLOBAL)) &&
                       dst_ip_i[111:16] == 96'h0000_0000_0000_0000_0000_0000 &&
                       dst_ip_i[15:0] == group_i);
endmodule

//--- prd_cfg_store.v
`timescale 1ns/100ps

// holds the parsing configuration and the custom mac address
module prd_cfg_store #(
    parameter CFG_WIDTH = 15
) (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // write side
    input  wire                 cfg_we_i,
    input  wire [CFG_WIDTH-1:0] cfg_wdata_i,
    input  wire                 mac_hi_we_i,
    input  wire [15:0]          mac_hi_wdata_i,
    input  wire                 mac_lo_we_i,
    input  wire [31:0]          mac_lo_wdata_i,
    // stored values
    output reg  [CFG_WIDTH-1:0] cfg_o,
    output reg  [47:0]          mac_o
);
`include "prd_defines.vh"

    // documented defaults come back on reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= `PRD_CFG_RESET;
            mac_o <= 48'h0000_0000_0000;
        end else begin
            if (cfg_we_i) begin
                cfg_o <= cfg_wdata_i;
            end
            if (mac_hi_we_i) begin
                mac_o[47:32] <= mac_hi_wdata_i;
            end
            if (mac_lo_we_i) begin
                mac_o[31:0] <= mac_lo_wdata_i;
            end
        end
    end
endmodule

//--- prd_rx_detect_assertions.sv
`timescale 1ns/100ps
`include "prd_defines.vh"
// ----------------------------------------
// checker beside the detector ports
// ----------------------------------------
module prd_rx_chk (
    // clock and reset
    input wire         clk_i,
    input wire         rst_i,
    // register bus
    input wire         cyc_i,
    input wire         stb_i,
    input wire         we_i,
    input wire [11:0]  adr_i,
    input wire [3:0]   sel_i,
    input wire [31:0]  dat_i,
    input wire [31:0]  dat_o,
    input wire         ack_o,
    // frame side
    input wire         hdr_valid_i,
    input wire [1:0]   hdr_enc_i,
    input wire [47:0]  hdr_dst_mac_i,
    input wire         res_valid_o,
    input wire         res_timing_o,
    input wire         ts_enable_o
);
    reg  [14:0] shd_reg;
    wire        req = cyc_i && stb_i && !ack_o;
    wire        raw = hdr_valid_i && hdr_enc_i == `PRD_ENC_RAW;
    wire        l2a = hdr_dst_mac_i == `PRD_MAC_L2_ONE;
    wire        l2b = hdr_dst_mac_i == `PRD_MAC_L2_TWO;
    // shadow config; writes dropped while timestamping runs
    always @(posedge clk_i) begin
        if (rst_i) begin
            shd_reg <= 15'h711F;
        end else if (req && we_i && adr_i == `PRD_OFS_PARSE_CONFIG && sel_i[1:0] == 2'b11
                     && !ts_enable_o) begin
            shd_reg <= dat_i[14:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    ack_resp_a: assert property (req |=> ack_o)
        else $error("no ack one cycle after request");
    rsv_zero_a: assert property (
        ack_o && !$past(we_i) && $past(adr_i) == `PRD_OFS_PARSE_CONFIG |-> ~|dat_o[31:15])
        else $error("reserved bits not zero");
    res_follow_a: assert property (hdr_valid_i |=> res_valid_o)
        else $error("no result after header");
    no_cand_a: assert property (
        hdr_valid_i && hdr_enc_i == `PRD_ENC_NONE |=> !res_timing_o)
        else $error("non candidate classed as timing");
    raw_off_a: assert property (raw && !shd_reg[2] |=> !res_timing_o)
        else $error("raw format accepted while off");
    v6_off_a: assert property (
        hdr_valid_i && hdr_enc_i == `PRD_ENC_V6 && !shd_reg[1] |=> !res_timing_o)
        else $error("v6 accepted while off");
    v4_off_a: assert property (
        hdr_valid_i && hdr_enc_i == `PRD_ENC_V4 && !shd_reg[0] |=> !res_timing_o)
        else $error("v4 accepted while off");
    l2_one_a: assert property (
        raw && shd_reg[2] && shd_reg[14] && l2a |=> res_timing_o)
        else $error("fixed address one refused");
    mac_chk_a: assert property (
        raw && shd_reg[3] && !shd_reg[7] && !l2a && !l2b |=> !res_timing_o)
        else $error("unknown mac accepted");
    cover property (res_valid_o && res_timing_o);
    cover property (res_valid_o && !res_timing_o);
    cover property (ack_o && ts_enable_o);
endmodule

bind prd_rx_detect prd_rx_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .hdr_valid_i(hdr_valid_i), .hdr_enc_i(hdr_enc_i), .hdr_dst_mac_i(hdr_dst_mac_i),
    .res_valid_o(res_valid_o), .res_timing_o(res_timing_o), .ts_enable_o(ts_enable_o));

//--- prd_rx_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// receive path model delivering headers
// ----------------------------------------
module prd_rx_source (
    // clock
    input  wire         clk_i,
    // header towards the detector
    output reg          hdr_valid_o,
    output reg  [1:0]   hdr_enc_o,
    output reg  [47:0]  hdr_dst_mac_o,
    output reg  [127:0] hdr_dst_ip_o
);
    // quiet at start
    initial begin
        hdr_valid_o = 1'b0;
        hdr_enc_o = 2'h3;
        hdr_dst_mac_o = 48'h0;
        hdr_dst_ip_o = 128'h0;
    end
    // one pulse per call; fields then invert so a stale header never matches
    task send(input [1:0] enc, input [47:0] mac, input [127:0] ip);
        begin
            @(posedge clk_i);
            hdr_valid_o   <= 1'b1;
            hdr_enc_o     <= enc;
            hdr_dst_mac_o <= mac;
            hdr_dst_ip_o  <= ip;
            @(posedge clk_i);
            hdr_valid_o   <= 1'b0;
            hdr_enc_o     <= ~enc;
            hdr_dst_mac_o <= ~mac;
            hdr_dst_ip_o  <= ~ip;
        end
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "prd_defines.vh"
// ----------------------------------------
// bench for the receive detection config
// ----------------------------------------
module testbench;
    localparam [11:0] CFG = `PRD_OFS_PARSE_CONFIG;
    localparam [47:0] CMAC = 48'h0A0B_0C0D_0E0F;
    reg          clk_i = 1'b0;
    reg          rst_i = 1'b1;
    reg          cyc_i = 1'b0;
    reg          stb_i = 1'b0;
    reg          we_i  = 1'b0;
    reg  [11:0]  adr_i = 12'h000;
    reg  [31:0]  dat_i = 32'h0000_0000;
    wire [31:0]  dat_o;
    wire         ack_o;
    wire         hv;
    wire [1:0]   he;
    wire [47:0]  hm;
    wire [127:0] hi;
    wire         res_valid_o;
    wire         res_timing_o;
    wire         ts_enable_o;
    reg  [31:0]  rd;
    integer      err_total = 0;
    integer      samples_checked = 0;
    integer      i;
    // 125 MHz
    always #4 clk_i = ~clk_i;
    prd_rx_source src (.clk_i(clk_i), .hdr_valid_o(hv), .hdr_enc_o(he),
        .hdr_dst_mac_o(hm), .hdr_dst_ip_o(hi));
    prd_rx_detect dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .hdr_valid_i(hv), .hdr_enc_i(he), .hdr_dst_mac_i(hm),
        .hdr_dst_ip_i(hi), .res_valid_o(res_valid_o), .res_timing_o(res_timing_o),
        .ts_enable_o(ts_enable_o));
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    task check(input string nm, input [31:0] exp, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // classic cycle; ack and read data are taken at the same rising edge
    task wb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i  <= w;
            adr_i <= a;
            dat_i <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && n < 16) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (ack_o !== 1'b1) begin
                check("ack", 32'h1, 32'h0);
                final_report;
            end else begin
                rd = dat_o;
                cyc_i <= 1'b0;
                stb_i <= 1'b0;
            end
        end
    endtask
    // header in, result one cycle later
    task frm(input [1:0] e, input [47:0] m, input [127:0] ip, input x);
        begin
            src.send(e, m, ip);
            @(negedge clk_i);
            check("class", {30'h0, 1'b1, x}, {30'h0, res_valid_o, res_timing_o});
        end
    endtask
    task v4(input [15:0] g, input x);
        frm(`PRD_ENC_V4, {32'h0100_5E00, g}, {96'h0, 16'hE000, g}, x);
    endtask
    task v6(input [15:0] g, input x);
        frm(`PRD_ENC_V6, {32'h3333_0000, g},
            {(g == `PRD_GROUP_FIVE) ? 16'hFF02 : 16'hFF05, 96'h0, g}, x);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CFG, 32'h0);
        check("cfg", 32'h0000_711F, rd);
        wb(1'b0, 12'h0F0, 32'h0);
        check("unmapped", 32'h0, rd);
        frm(`PRD_ENC_RAW, `PRD_MAC_L2_ONE, 128'h0, 1'b1);
        frm(`PRD_ENC_RAW, `PRD_MAC_L2_TWO, 128'h0, 1'b1);
        frm(`PRD_ENC_RAW, 48'h0180_C200_000F, 128'h0, 1'b0);
        frm(`PRD_ENC_NONE, `PRD_MAC_L2_ONE, 128'h0, 1'b0);
        v4(`PRD_GROUP_ONE, 1'b1);
        v6(`PRD_GROUP_FIVE, 1'b1);
        v4(`PRD_GROUP_TWO, 1'b0);
        $display("test defaults done");
        wb(1'b1, CFG, 32'hFFFF_FFFF);
        wb(1'b0, CFG, 32'h0);
        check("cfg_rsv", 32'h0000_7FFF, rd);
        for (i = 0; i < 4; i = i + 1) begin
            v4(16'h0181 + i[15:0], 1'b1);
            v6(16'h0181 + i[15:0], 1'b1);
        end
        frm(`PRD_ENC_V4, 48'h0100_5E00_0181, {96'h0, 32'hE000_0199}, 1'b0);
        wb(1'b1, CFG, 32'h0000_7FE7);
        frm(`PRD_ENC_V4, 48'h0100_5E00_0181, {96'h0, 32'hE000_0199}, 1'b1);
        frm(`PRD_ENC_RAW, 48'h0180_C200_000F, 128'h0, 1'b1);
        $display("test groups done");
        wb(1'b1, `PRD_OFS_MAC_HIGH, 32'h0000_0A0B);
        wb(1'b1, `PRD_OFS_MAC_LOW, 32'h0C0D_0E0F);
        wb(1'b0, `PRD_OFS_MAC_HIGH, 32'h0);
        check("mac_hi", 32'h0000_0A0B, rd);
        wb(1'b0, `PRD_OFS_MAC_LOW, 32'h0);
        check("mac_lo", 32'h0C0D_0E0F, rd);
        wb(1'b1, CFG, 32'h0000_10FF);
        frm(`PRD_ENC_RAW, CMAC, 128'h0, 1'b1);
        frm(`PRD_ENC_V6, CMAC, {16'hFF05, 96'h0, 16'h0181}, 1'b1);
        frm(`PRD_ENC_V4, CMAC, {96'h0, 32'hE000_0181}, 1'b1);
        wb(1'b1, CFG, 32'h0000_101F);
        frm(`PRD_ENC_RAW, CMAC, 128'h0, 1'b0);
        $display("test custom done");
        wb(1'b1, CFG, 32'h0000_7FF8);
        frm(`PRD_ENC_RAW, `PRD_MAC_L2_ONE, 128'h0, 1'b0);
        v6(`PRD_GROUP_ONE, 1'b0);
        v4(`PRD_GROUP_ONE, 1'b0);
        // a write while timestamping runs must be dropped
        wb(1'b1, `PRD_OFS_CONTROL, 32'h0000_0001);
        @(negedge clk_i);
        check("ts_en", 32'h1, {31'h0, ts_enable_o});
        wb(1'b1, CFG, 32'h0000_711F);
        wb(1'b0, CFG, 32'h0);
        check("cfg_lock", 32'h0000_7FF8, rd);
        wb(1'b1, `PRD_OFS_CONTROL, 32'h0);
        @(negedge clk_i);
        check("ts_off", 32'h0, {31'h0, ts_enable_o});
        // 25 headers sent so far, 17 of them timing messages
        wb(1'b0, `PRD_OFS_STATUS, 32'h0);
        check("status", 32'h0011_0019, rd);
        $display("test formats done");
        final_report;
    end
endmodule
